// ===== rtl/line_ctrl_pkg.sv
// Constants, offsets and reset values of the parallel line controller.
// Assumes a 32-bit Avalon-MM slave with byte addresses on a 125 MHz clock.
// Function
// - Ownership enable write 1 gives line to controller
// - Ownership disable write 1 gives line to peripheral
// - Ownership status reads 1 when controller owns
// - Driver enable write 1 turns driver on
// - Driver disable write 1 turns driver off
// - Driver status reads 1 when output enabled
// - Filter enable write 1 switches filter on
// - Filter disable write 1 switches filter off
// - Filter status reads 1 while filter active
// - Level set write 1 schedules high level
// - Level clear write 1 schedules low level
// - Level status returns scheduled drive level
// - Direct level writes only on permitted lines
// - Select A clears status, select B sets
// - Pin levels sampled only while clock enabled
// - Change status resets zero, records later changes
// - Ownership reset value set per product
// - Registers 32 bits; undefined lines read zero
// - Reading change status clears all pending bits
package line_ctrl_pkg;

   // ************************************************************
   // Register byte offsets
   // ************************************************************
   localparam logic [7:0] OFS_OWN_EN      = 8'h00;
   localparam logic [7:0] OFS_OWN_DIS     = 8'h04;
   localparam logic [7:0] OFS_OWN_STAT    = 8'h08;
   localparam logic [7:0] OFS_DRV_EN      = 8'h10;
   localparam logic [7:0] OFS_DRV_DIS     = 8'h14;
   localparam logic [7:0] OFS_DRV_STAT    = 8'h18;
   localparam logic [7:0] OFS_FLT_EN      = 8'h20;
   localparam logic [7:0] OFS_FLT_DIS     = 8'h24;
   localparam logic [7:0] OFS_FLT_STAT    = 8'h28;
   localparam logic [7:0] OFS_LVL_SET     = 8'h30;
   localparam logic [7:0] OFS_LVL_CLR     = 8'h34;
   localparam logic [7:0] OFS_LVL_STAT    = 8'h38;
   localparam logic [7:0] OFS_PIN_STAT    = 8'h3C;
   localparam logic [7:0] OFS_CHG_STAT    = 8'h4C;
   localparam logic [7:0] OFS_SEL_A       = 8'h70;
   localparam logic [7:0] OFS_SEL_B       = 8'h74;
   localparam logic [7:0] OFS_SEL_STAT    = 8'h78;
   localparam logic [7:0] OFS_PERMIT_EN   = 8'hA0;
   localparam logic [7:0] OFS_PERMIT_DIS  = 8'hA4;
   localparam logic [7:0] OFS_PERMIT_STAT = 8'hA8;
   localparam logic [7:0] OFS_CLK_CTRL    = 8'hB0;

   // ************************************************************
   // Reset values and line map
   // ************************************************************
   localparam logic [31:0] RST_ZERO       = 32'h0000_0000;
   localparam logic [31:0] RST_OWN_STAT   = 32'hFFFF_FFFF;
   localparam logic [31:0] LINE_MASK_DEF  = 32'hFFFF_FFFF;
   localparam logic [31:0] MUXED_MASK_DEF = 32'hFFFF_FFFF;
   localparam logic        RST_CLK_EN     = 1'b1;

   // Bus answer states
   typedef enum logic [0:0]
   {
      BUS_IDLE = 1'b0,
      BUS_DONE = 1'b1
   } bus_state_t;

endpackage

// ===== rtl/line_controller.sv
// Register control of a 32-line parallel I/O controller.
// Assumes an Avalon-MM master; pin inputs are synchronous to sys_clk.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module line_controller
   import line_ctrl_pkg::*;
#(
   parameter logic [31:0] LINE_MASK    = LINE_MASK_DEF,
   parameter logic [31:0] MUXED_MASK   = MUXED_MASK_DEF,
   parameter logic [31:0] OWN_RST_VAL  = RST_OWN_STAT
)
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // Avalon-MM slave
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   output logic      [1:0]  response,
   // Line levels
   input  wire logic [31:0] pin_in,
   // Line configuration outputs
   output logic      [31:0] line_owned,
   output logic      [31:0] drive_enable,
   output logic      [31:0] filter_enable,
   output logic      [31:0] drive_level,
   output logic      [31:0] periph_b_sel,
   output logic      [31:0] permit
);

   // ************************************************************
   // Declarations
   // ************************************************************
   bus_state_t  bus_q;            // Answer state
   logic [31:0] own_q;            // Ownership status
   logic [31:0] drv_q;            // Driver status
   logic [31:0] flt_q;            // Filter status
   logic [31:0] lvl_q;            // Scheduled level
   logic [31:0] sel_q;            // Peripheral B selected
   logic [31:0] perm_q;           // Output write permit
   logic [31:0] pin_q;            // Sampled pin levels
   logic [31:0] pin_prev_q;       // Previous sample
   logic [31:0] chg_q;            // Input change flags
   logic        clk_en_q;         // Controller clock enable
   logic        primed_q;         // A first sample exists
   logic [31:0] rdata_d;          // Read mux value
   logic        hit_d;            // Address is mapped
   logic [31:0] wmask;            // Byte lane mask
   logic [31:0] wbits;            // Written ones on defined lines
   logic        wr_go;            // Write takes effect
   logic        rd_go;            // Read is answered
   logic [31:0] chg_new;          // Changes seen this cycle

   // ************************************************************
   // Bus handshake
   // ************************************************************
   // One wait cycle then answer; writes act at the answer edge, reads capture data at the edge before it
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         bus_q <= BUS_IDLE;
      end
      else if (bus_q == BUS_DONE)
      begin
         bus_q <= BUS_IDLE;
      end
      else if (read || write)
      begin
         bus_q <= BUS_DONE;
      end
   end

   assign waitrequest = (read || write) && (bus_q == BUS_IDLE);
   assign wr_go       = write && (bus_q == BUS_DONE);
   assign rd_go       = read && (bus_q == BUS_DONE);

   // Byte lanes and defined lines gate every written line bit; lane 0 alone gates the clock control bit
   // undefined lines ignore writes
   always_comb
   begin
      wmask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
      wbits = writedata & wmask & LINE_MASK;
   end

   // ************************************************************
   // Ownership register
   // ************************************************************
   // Set by enable, cleared by disable; unmuxed lines stay owned
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         own_q <= OWN_RST_VAL;
      end
      else if (wr_go && address == OFS_OWN_EN)
      begin
         own_q <= own_q | wbits;
      end
      else if (wr_go && address == OFS_OWN_DIS)
      begin
         own_q <= own_q & ~(wbits & MUXED_MASK);
      end
   end

   // ************************************************************
   // Output driver register
   // ************************************************************
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         drv_q <= RST_ZERO;
      end
      else if (wr_go && address == OFS_DRV_EN)
      begin
         drv_q <= drv_q | wbits;
      end
      else if (wr_go && address == OFS_DRV_DIS)
      begin
         drv_q <= drv_q & ~wbits;
      end
   end

   // ************************************************************
   // Glitch filter register
   // ************************************************************
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         flt_q <= RST_ZERO;
      end
      else if (wr_go && address == OFS_FLT_EN)
      begin
         flt_q <= flt_q | wbits;
      end
      else if (wr_go && address == OFS_FLT_DIS)
      begin
         flt_q <= flt_q & ~wbits;
      end
   end

   // ************************************************************
   // Output level register
   // ************************************************************
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         lvl_q <= RST_ZERO;
      end
      else if (wr_go && address == OFS_LVL_SET)
      begin
         lvl_q <= lvl_q | wbits;
      end
      else if (wr_go && address == OFS_LVL_CLR)
      begin
         lvl_q <= lvl_q & ~wbits;
      end
      else if (wr_go && address == OFS_LVL_STAT)
      begin
         lvl_q <= (lvl_q & ~(perm_q & wmask & LINE_MASK)) | (wbits & perm_q);
      end
   end

   // ************************************************************
   // Peripheral selection register
   // ************************************************************
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         sel_q <= RST_ZERO;
      end
      else if (wr_go && address == OFS_SEL_A)
      begin
         sel_q <= sel_q & ~wbits;
      end
      else if (wr_go && address == OFS_SEL_B)
      begin
         sel_q <= sel_q | wbits;
      end
   end

   // ************************************************************
   // Output write permission register
   // ************************************************************
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         perm_q <= RST_ZERO;
      end
      else if (wr_go && address == OFS_PERMIT_EN)
      begin
         perm_q <= perm_q | wbits;
      end
      else if (wr_go && address == OFS_PERMIT_DIS)
      begin
         perm_q <= perm_q & ~wbits;
      end
   end

   // ************************************************************
   // Controller clock enable
   // ************************************************************
   // Bit 0 of the clock control register gates sampling
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         clk_en_q <= RST_CLK_EN;
      end
      else if (wr_go && address == OFS_CLK_CTRL && byteenable[0])
      begin
         clk_en_q <= writedata[0];
      end
   end

   // ************************************************************
   // Pin sampling
   // ************************************************************
   // Samples freeze while the clock is off
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         pin_q      <= RST_ZERO;
         pin_prev_q <= RST_ZERO;
         primed_q   <= 1'b0;
      end
      else if (clk_en_q)
      begin
         pin_q      <= pin_in & LINE_MASK;
         pin_prev_q <= pin_q;
         primed_q   <= 1'b1;
      end
   end

   // Current sample is compared with the previous one; the first sample with the reset zero
   assign chg_new = (primed_q && clk_en_q) ? (pin_q ^ pin_prev_q) : RST_ZERO;

   // ************************************************************
   // Input change status
   // ************************************************************
   // Cleared at the edge that captures the read data, so no change is lost
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         chg_q <= RST_ZERO;
      end
      else if (read && bus_q == BUS_IDLE && address == OFS_CHG_STAT)
      begin
         chg_q <= chg_new;
      end
      else
      begin
         chg_q <= chg_q | chg_new;
      end
   end

   // ************************************************************
   // Read data
   // ************************************************************
   always_comb
   begin
      hit_d   = 1'b1;
      rdata_d = RST_ZERO;
      case (address)
         OFS_OWN_STAT:    rdata_d = own_q;
         OFS_DRV_STAT:    rdata_d = drv_q;
         OFS_FLT_STAT:    rdata_d = flt_q;
         OFS_LVL_STAT:    rdata_d = lvl_q;
         OFS_PIN_STAT:    rdata_d = pin_q;
         OFS_CHG_STAT:    rdata_d = chg_q;
         OFS_SEL_STAT:    rdata_d = sel_q;
         OFS_PERMIT_STAT: rdata_d = perm_q;
         OFS_CLK_CTRL:    rdata_d = {31'h0000_0000, clk_en_q};
         OFS_OWN_EN, OFS_OWN_DIS, OFS_DRV_EN, OFS_DRV_DIS, OFS_FLT_EN, OFS_FLT_DIS,
         OFS_LVL_SET, OFS_LVL_CLR, OFS_SEL_A, OFS_SEL_B, OFS_PERMIT_EN, OFS_PERMIT_DIS:
            rdata_d = RST_ZERO;
         default:         hit_d = 1'b0;
      endcase
   end

   // Read data registered; stands during the answer cycle
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         readdata <= RST_ZERO;
         response <= 2'h0;
      end
      else if ((read || write) && bus_q == BUS_IDLE)
      begin
         readdata <= rdata_d & ((address == OFS_CLK_CTRL) ? 32'hFFFF_FFFF : LINE_MASK);
         response <= hit_d ? 2'h0 : 2'h2;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign line_owned    = own_q;
   assign drive_enable  = drv_q;
   assign filter_enable = flt_q;
   assign drive_level   = lvl_q;
   assign periph_b_sel  = sel_q;
   assign permit        = perm_q;

   // ************************************************************
   // Assertions
   // ************************************************************
   a_own_enable: assert property (@(posedge sys_clk) disable iff (rst)
      wr_go && address == OFS_OWN_EN |=> ((own_q & $past(wbits)) == $past(wbits)))
      else $error("ownership enable did not set line");
   a_own_disable: assert property (@(posedge sys_clk) disable iff (rst)
      wr_go && address == OFS_OWN_DIS |=> ((own_q & $past(wbits) & MUXED_MASK) == 32'h0))
      else $error("ownership disable did not clear line");
   a_drv_pair: assert property (@(posedge sys_clk) disable iff (rst)
      wr_go && address == OFS_DRV_DIS |=> ((drv_q & $past(wbits)) == 32'h0))
      else $error("driver disable failed");
   a_flt_hold: assert property (@(posedge sys_clk) disable iff (rst)
      !(wr_go && (address == OFS_FLT_EN || address == OFS_FLT_DIS)) |=> $stable(flt_q))
      else $error("filter changed without write");
   a_lvl_permit: assert property (@(posedge sys_clk) disable iff (rst)
      wr_go && address == OFS_LVL_STAT |=> (((lvl_q ^ $past(lvl_q)) & ~$past(perm_q)) == 32'h0))
      else $error("level written on unpermitted line");
   a_sel_b_sets: assert property (@(posedge sys_clk) disable iff (rst)
      wr_go && address == OFS_SEL_B |=> ((sel_q & $past(wbits)) == $past(wbits)))
      else $error("select B did not set status");
   a_pin_freeze: assert property (@(posedge sys_clk) disable iff (rst)
      !clk_en_q |=> $stable(pin_q))
      else $error("pins sampled while clock off");
   a_chg_clear: assert property (@(posedge sys_clk) disable iff (rst)
      read && bus_q == BUS_IDLE && address == OFS_CHG_STAT |=> (chg_q == $past(chg_new)))
      else $error("change status not cleared by read");
   a_wait_one: assert property (@(posedge sys_clk) disable iff (rst)
      (read || write) && bus_q == BUS_IDLE |=> !waitrequest)
      else $error("answer not given after one wait");

   c_own_dis: cover property (@(posedge sys_clk) wr_go && address == OFS_OWN_DIS);
   c_lvl_direct: cover property (@(posedge sys_clk) wr_go && address == OFS_LVL_STAT && perm_q != 32'h0);
   c_chg_read: cover property (@(posedge sys_clk) rd_go && address == OFS_CHG_STAT && chg_q != 32'h0);

endmodule
`default_nettype wire

// ===== tb/pin_model.sv
// Model of the pins and the far-side devices of the line controller.
// Assumes the controller's outputs are stable registers on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module pin_model
(
   // Controller line configuration
   input  wire logic [31:0] line_owned,
   input  wire logic [31:0] drive_enable,
   input  wire logic [31:0] drive_level,
   // Level that outside devices put on undriven lines
   input  wire logic [31:0] ext_level,
   // Resolved pin levels
   output logic      [31:0] pin_level
);
   // Lines driven by the controller
   logic [31:0] driven;

   // The controller wins a line only when it owns it and its driver is on
   assign driven    = line_owned & drive_enable;
   assign pin_level = (driven & drive_level) | (~driven & ext_level);
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench of the line controller register block.
// Assumes the package offsets and one wait state per bus access.
`timescale 1ns/1ps
`default_nettype none
module tb
   import line_ctrl_pkg::*;
;
   // ************************************************************
   // Signals
   // ************************************************************
   logic        sys_clk;
   logic        rst;
   logic [7:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [3:0]  byteenable;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [1:0]  response;
   logic [31:0] pin_in;
   logic [31:0] ext_level;
   logic [31:0] line_owned;
   logic [31:0] drive_enable;
   logic [31:0] filter_enable;
   logic [31:0] drive_level;
   logic [31:0] periph_b_sel;
   logic [31:0] permit;
   logic [31:0] rd_q;
   logic [1:0]  resp_q;
   int          bad_count;
   int          num_checks;

   line_controller i_dut
   (
      .sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .response(response), .pin_in(pin_in),
      .line_owned(line_owned), .drive_enable(drive_enable), .filter_enable(filter_enable),
      .drive_level(drive_level), .periph_b_sel(periph_b_sel), .permit(permit)
   );

   pin_model i_pins
   (
      .line_owned(line_owned), .drive_enable(drive_enable), .drive_level(drive_level),
      .ext_level(ext_level), .pin_level(pin_in)
   );

   // Clock generator, 8 ns period
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // ************************************************************
   // Shared tasks
   // ************************************************************
   // Compare and count
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One bus access; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge sys_clk);
      address    <= a;
      write      <= wr;
      read       <= ~wr;
      writedata  <= d;
      byteenable <= be;
      @(posedge sys_clk);
      // Only the watchdog ends a wait that never gets an answer
      while (waitrequest !== 1'b0)
      begin
         @(posedge sys_clk);
      end
      rd_q   = readdata;
      resp_q = response;
      write <= 1'b0;
      read  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
      bus(1'b0, a, 32'h0000_0000, 4'hF);
      check(name, rd_q, exp);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset();
      rd_chk(OFS_OWN_STAT, 32'hFFFF_FFFF, "own reset");
      rd_chk(OFS_DRV_STAT, 32'h0000_0000, "drv reset");
      rd_chk(OFS_FLT_STAT, 32'h0000_0000, "flt reset");
      rd_chk(OFS_LVL_STAT, 32'h0000_0000, "lvl reset");
      rd_chk(OFS_SEL_STAT, 32'h0000_0000, "sel reset");
      rd_chk(OFS_PERMIT_STAT, 32'h0000_0000, "permit reset");
      rd_chk(OFS_CHG_STAT, 32'h0000_0000, "chg reset");
      $display("test reset done");
   endtask

   task automatic t_own();
      wr(OFS_OWN_DIS, 32'h0000_FFFF);
      rd_chk(OFS_OWN_STAT, 32'hFFFF_0000, "own dis");
      wr(OFS_OWN_EN, 32'h0000_0F00);
      wr(OFS_OWN_EN, 32'h0000_0000);
      rd_chk(OFS_OWN_STAT, 32'hFFFF_0F00, "own en");
      check("own port", line_owned, 32'hFFFF_0F00);
      $display("test ownership done");
   endtask

   // Driver and filter share one enable, disable, status layout
   task automatic t_pairs();
      logic [7:0] base [2];
      base = '{OFS_DRV_EN, OFS_FLT_EN};
      for (int i = 0; i < 2; i++)
      begin
         wr(base[i], 32'hA5A5_0F0F);
         rd_chk(base[i] + 8'h08, 32'hA5A5_0F0F, "pair en");
         wr(base[i] + 8'h04, 32'h0000_0F0F);
         wr(base[i], 32'h0000_0000);
         rd_chk(base[i] + 8'h08, 32'hA5A5_0000, "pair dis");
      end
      check("drv port", drive_enable, 32'hA5A5_0000);
      check("flt port", filter_enable, 32'hA5A5_0000);
      $display("test pairs done");
   endtask

   task automatic t_level();
      wr(OFS_LVL_SET, 32'hFF00_00FF);
      wr(OFS_LVL_CLR, 32'h0F00_000F);
      rd_chk(OFS_LVL_STAT, 32'hF000_00F0, "lvl set clr");
      bus(1'b1, OFS_LVL_SET, 32'hFFFF_FFFF, 4'h1);
      rd_chk(OFS_LVL_STAT, 32'hF000_00FF, "lvl lane");
      wr(OFS_PERMIT_EN, 32'h0000_FFFF);
      wr(OFS_PERMIT_DIS, 32'h0000_F000);
      rd_chk(OFS_PERMIT_STAT, 32'h0000_0FFF, "permit");
      check("permit port", permit, 32'h0000_0FFF);
      wr(OFS_LVL_STAT, 32'h1234_5678);
      rd_chk(OFS_LVL_STAT, 32'hF000_0678, "lvl direct");
      check("lvl port", drive_level, 32'hF000_0678);
      $display("test level done");
   endtask

   task automatic t_select();
      wr(OFS_SEL_B, 32'h00F0_0000);
      wr(OFS_SEL_A, 32'h0030_0000);
      rd_chk(OFS_SEL_STAT, 32'h00C0_0000, "sel");
      check("sel port", periph_b_sel, 32'h00C0_0000);
      $display("test select done");
   endtask

   // Lines A5A5_0000 are driven at level F000_0678, the rest follow ext_level
   task automatic t_pins();
      ext_level <= 32'h0000_005A;
      repeat (4) @(posedge sys_clk);
      rd_chk(OFS_PIN_STAT, 32'hA000_005A, "pins live");
      wr(OFS_CLK_CTRL, 32'h0000_0000);
      ext_level <= 32'h0000_00A5;
      repeat (4) @(posedge sys_clk);
      rd_chk(OFS_PIN_STAT, 32'hA000_005A, "pins frozen");
      wr(OFS_CLK_CTRL, 32'h0000_0001);
      repeat (4) @(posedge sys_clk);
      rd_chk(OFS_PIN_STAT, 32'hA000_00A5, "pins resumed");
      $display("test pins done");
   endtask

   task automatic t_change();
      bus(1'b0, OFS_CHG_STAT, 32'h0000_0000, 4'hF);
      rd_chk(OFS_CHG_STAT, 32'h0000_0000, "chg cleared");
      ext_level <= 32'h0000_00B5;
      repeat (4) @(posedge sys_clk);
      rd_chk(OFS_CHG_STAT, 32'h0000_0010, "chg seen");
      rd_chk(OFS_CHG_STAT, 32'h0000_0000, "chg read clear");
      $display("test change done");
   endtask

   task automatic t_refuse();
      bus(1'b0, 8'h0C, 32'h0000_0000, 4'hF);
      check("hole data", rd_q, 32'h0000_0000);
      check("hole resp", {30'h0, resp_q}, 32'h0000_0002);
      wr(8'h0C, 32'hFFFF_FFFF);
      wr(OFS_OWN_STAT, 32'h0000_0000);
      rd_chk(OFS_OWN_STAT, 32'hFFFF_0F00, "own read only");
      check("ok resp", {30'h0, resp_q}, 32'h0000_0000);
      $display("test refuse done");
   endtask

   // ************************************************************
   // Verdict and main sequence
   // ************************************************************
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Watchdog well beyond the roughly 160 cycles the tests need
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      end_of_test();
   end

   initial
   begin
      bad_count  = 0;
      num_checks = 0;
      rst        = 1'b1;
      address    = 8'h00;
      read       = 1'b0;
      write      = 1'b0;
      writedata  = 32'h0000_0000;
      byteenable = 4'hF;
      ext_level  = 32'h0000_0000;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_own();
      t_pairs();
      t_level();
      t_select();
      t_pins();
      t_change();
      t_refuse();
      end_of_test();
   end
endmodule
`default_nettype wire
